// *** fes_pkg.sv ***
// package: register map, field layout and carriers for the erase/overlay block
package fes_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;

  // control register window, reachable only while the window enable is set
  localparam logic [23:0] FES_ADDR_WIN_LO = 24'hffffa8;
  localparam logic [23:0] FES_ADDR_WIN_HI = 24'hffffac;
  localparam logic [23:0] FES_ADDR_STATUS = 24'hffffa9;
  localparam logic [23:0] FES_ADDR_SEL_LO = 24'hffffaa;
  localparam logic [23:0] FES_ADDR_SEL_HI = 24'hffffab;
  // overlay control sits outside the window and is always reachable
  localparam logic [23:0] FES_ADDR_OVL = 24'hfffedb;

  // field positions
  localparam int FES_STATUS_ERR_BIT = 7;
  localparam int FES_OVL_EN_BIT = 3;
  localparam int FES_OVL_AREA_LSB = 0;
  localparam int FES_OVL_AREA_W = 3;
  localparam int FES_OVL_W = 5;
  localparam int FES_SEL_LO_W = 8;
  localparam int FES_SEL_HI_W = 4;
  localparam int FES_BLOCKS = 12;

  // reset values
  localparam logic [7:0] FES_SEL_LO_RST = 8'h00;
  localparam logic [3:0] FES_SEL_HI_RST = 4'h0;
  localparam logic [4:0] FES_OVL_RST = 5'h00;

  // flash block geometry
  localparam logic [23:0] FES_SMALL_BLK = 24'h001000;
  localparam logic [23:0] FES_MID_BASE = 24'h008000;
  localparam logic [23:0] FES_MID_LAST = 24'h00ffff;
  localparam logic [23:0] FES_BIG_BASE = 24'h010000;
  localparam logic [23:0] FES_BIG_BLK = 24'h010000;
  localparam int FES_SMALL_COUNT = 8;
  localparam int FES_MID_INDEX = 8;

  // ram window that stands in for the overlaid block
  localparam logic [23:0] FES_RAM_OVL_BASE = 24'hffd000;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [23:0] addr;
    logic [7:0] wdata;
  } fes_bus_req_s;

  typedef struct packed {
    logic redirect;
    logic [23:0] ram_addr;
    logic erase_any;
    logic [23:0] erase_start;
    logic [23:0] erase_last;
  } fes_map_s;

  typedef struct packed {
    logic err;
    logic [7:0] sel_lo;
    logic [3:0] sel_hi;
    logic [4:0] ovl;
    logic [7:0] rdata;
    logic rvalid;
    logic [11:0] erase_mask;
    logic [23:0] erase_start;
    logic [23:0] erase_last;
    logic erase_valid;
    logic redirect;
    logic [23:0] ram_addr;
    logic protect;
  } fes_state_s;

  localparam fes_state_s FES_STATE_RST = '0;

  function automatic logic [3:0] fes_ones(input logic [11:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < FES_BLOCKS; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

endpackage

// *** fes_map.sv ***
// address mapping: overlay redirect and erase range of the selected block
`timescale 1ns/100ps
module fes_map
  import fes_pkg::*;
(
  // cpu read
  input wire logic rd,
  input wire logic [23:0] addr,
  // settings
  input wire logic [4:0] ovl,
  input wire logic [11:0] sel,
  // result
  output fes_pkg::fes_map_s map
);

  // first address of block idx; 0..7 small, 8 mid, 9..11 big
  function automatic logic [23:0] blk_base(input logic [3:0] idx);
    logic [23:0] b;
    b = 24'h000000;
    if (idx < 4'(FES_SMALL_COUNT)) begin
      b = FES_SMALL_BLK * {20'h00000, idx};
    end else if (idx == 4'(FES_MID_INDEX)) begin
      b = FES_MID_BASE;
    end else begin
      b = FES_BIG_BASE + FES_BIG_BLK * {20'h00000, idx - 4'h9};
    end
    return b;
  endfunction

  logic [3:0] idx;
  logic [23:0] ovl_base;
  logic [2:0] area;

  always_comb begin
    area = ovl[FES_OVL_AREA_LSB +: FES_OVL_AREA_W];
    ovl_base = blk_base({1'b0, area});
    map.redirect = rd && ovl[FES_OVL_EN_BIT] &&
      (addr[23:12] == ovl_base[23:12]);
    map.ram_addr = FES_RAM_OVL_BASE | {12'h000, addr[11:0]};
    idx = 4'h0;
    for (int i = 0; i < FES_BLOCKS; i++) begin
      if (sel[i]) begin
        idx = 4'(i);
      end
    end
    map.erase_any = |sel;
    map.erase_start = blk_base(idx);
    if (idx < 4'(FES_SMALL_COUNT)) begin
      map.erase_last = map.erase_start + FES_SMALL_BLK - 24'h000001;
    end else if (idx == 4'(FES_MID_INDEX)) begin
      map.erase_last = FES_MID_LAST;
    end else begin
      map.erase_last = map.erase_start + FES_BIG_BLK - 24'h000001;
    end
  end

endmodule

// *** fes_top.sv ***
// flash error status, erase block select and ram overlay control
`timescale 1ns/100ps
module fes_top
  import fes_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // cpu register and flash read port
  input fes_pkg::fes_bus_req_s bus_req,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  // from the mode control register and flash sequencer
  input wire logic software_write_enable,
  input wire logic flash_reg_window_enable,
  input wire logic prog_erase_fail,
  // erase target towards the sequencer
  output logic [11:0] erase_block_mask,
  output logic [23:0] erase_start_addr,
  output logic [23:0] erase_last_addr,
  output logic erase_valid,
  // protection and error state
  output logic flash_error_flag,
  output logic program_erase_protect,
  // overlay redirect towards the memory decoder
  output logic ram_redirect,
  output logic [23:0] ram_redirect_addr
);
  import fes_pkg::*;

  fes_state_s q;
  fes_state_s d;
  fes_map_s map;

  logic in_window;
  logic win_ok;
  logic wr_sel_lo;
  logic wr_sel_hi;
  logic wr_ovl;
  logic [7:0] lo_n;
  logic [3:0] hi_n;
  logic [11:0] sel_n;

  // mapping uses the registered settings, so an overlay write
  // only takes effect for accesses one cycle later
  fes_map u_map (
    .rd(bus_req.rd),
    .addr(bus_req.addr),
    .ovl(q.ovl),
    .sel({q.sel_hi, q.sel_lo}),
    .map(map)
  );

  // read value of one register address; unmapped reads as zero
  function automatic logic [7:0] reg_read(
    input fes_state_s s,
    input logic [23:0] a,
    input logic win
  );
    logic [7:0] r;
    r = 8'h00;
    if (a == FES_ADDR_OVL) begin
      r = {3'h0, s.ovl};
    end else if (win && a == FES_ADDR_STATUS) begin
      r = {s.err, 7'h00};
    end else if (win && a == FES_ADDR_SEL_LO) begin
      r = s.sel_lo;
    end else if (win && a == FES_ADDR_SEL_HI) begin
      r = {4'h0, s.sel_hi};
    end
    return r;
  endfunction

  always_comb begin
    d = q;

    // register window decode
    in_window = (bus_req.addr >= FES_ADDR_WIN_LO) &&
      (bus_req.addr <= FES_ADDR_WIN_HI);
    win_ok = in_window && flash_reg_window_enable;

    wr_sel_lo = bus_req.wr && win_ok &&
      (bus_req.addr == FES_ADDR_SEL_LO);
    wr_sel_hi = bus_req.wr && win_ok &&
      (bus_req.addr == FES_ADDR_SEL_HI);
    wr_ovl = bus_req.wr && (bus_req.addr == FES_ADDR_OVL);

    // read answer one cycle after the strobe
    d.rvalid = bus_req.rd;
    d.rdata = 8'h00;
    if (bus_req.rd) begin
      d.rdata = reg_read(q, bus_req.addr, flash_reg_window_enable);
    end

    // error flag is sticky; only reset clears it
    if (prog_erase_fail) begin
      d.err = 1'b1;
    end

    // writes to the status address fall through untouched

    // erase select update
    lo_n = q.sel_lo;
    hi_n = q.sel_hi;
    if (wr_sel_lo) begin
      lo_n = bus_req.wdata;
    end
    if (wr_sel_hi) begin
      hi_n = bus_req.wdata[FES_SEL_HI_W-1:0];
    end
    if (!software_write_enable) begin
      lo_n = FES_SEL_LO_RST;
      hi_n = FES_SEL_HI_RST;
    end
    sel_n = {hi_n, lo_n};
    if (fes_ones(sel_n) > 4'h1) begin
      lo_n = FES_SEL_LO_RST;
      hi_n = FES_SEL_HI_RST;
    end
    d.sel_lo = lo_n;
    d.sel_hi = hi_n;

    // overlay control; bits 7..5 are not stored and read zero
    if (wr_ovl) begin
      d.ovl = bus_req.wdata[FES_OVL_W-1:0];
    end

    // protection: error or active overlay withholds erase_valid; reads and redirect go on
    d.protect = d.err || d.ovl[FES_OVL_EN_BIT];

    // erase target; mask and range stay driven, only erase_valid is suppressed while protected
    d.erase_mask = {q.sel_hi, q.sel_lo};
    d.erase_start = map.erase_start;
    d.erase_last = map.erase_last;
    d.erase_valid = map.erase_any && !q.protect &&
      software_write_enable;

    // overlay redirect of flash reads
    d.redirect = map.redirect;
    d.ram_addr = map.redirect ? map.ram_addr : 24'h000000;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      q <= FES_STATE_RST;
    end else begin
      q <= d;
    end
  end

  // every output straight from the state register
  assign bus_rdata = q.rdata;
  assign bus_rvalid = q.rvalid;
  assign erase_block_mask = q.erase_mask;
  assign erase_start_addr = q.erase_start;
  assign erase_last_addr = q.erase_last;
  assign erase_valid = q.erase_valid;
  assign flash_error_flag = q.err;
  assign program_erase_protect = q.protect;
  assign ram_redirect = q.redirect;
  assign ram_redirect_addr = q.ram_addr;

endmodule

// *** fes_sva.sv ***
// assertions on the ports of the erase select and overlay block
`timescale 1ns/100ps
module fes_sva
  import fes_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // bus and controls
  input fes_pkg::fes_bus_req_s bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic software_write_enable,
  input wire logic flash_reg_window_enable,
  input wire logic prog_erase_fail,
  // results
  input wire logic [11:0] erase_block_mask,
  input wire logic [23:0] erase_start_addr,
  input wire logic [23:0] erase_last_addr,
  input wire logic erase_valid,
  input wire logic flash_error_flag,
  input wire logic program_erase_protect,
  input wire logic ram_redirect,
  input wire logic [23:0] ram_redirect_addr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence win_off_rd;
    bus_req.rd && !flash_reg_window_enable &&
      bus_req.addr inside {[FES_ADDR_WIN_LO:FES_ADDR_WIN_HI]};
  endsequence
  sequence stat_rd;
    bus_req.rd && flash_reg_window_enable && bus_req.addr == FES_ADDR_STATUS;
  endsequence
  err_set_a: assert property (prog_erase_fail |=> flash_error_flag)
    else $error("error flag not set");
  err_keep_a: assert property (flash_error_flag |=> flash_error_flag)
    else $error("error flag dropped");
  stat_read_a: assert property (stat_rd |=>
    bus_rdata == {$past(flash_error_flag), 7'h00})
    else $error("status read wrong");
  sel_off_a: assert property (!software_write_enable [*3] |=>
    erase_block_mask == 12'h000)
    else $error("select kept without enable");
  one_sel_a: assert property ($countones(erase_block_mask) <= 1)
    else $error("several blocks selected");
  mid_blk_a: assert property (erase_valid && erase_block_mask == 12'h100 |->
    erase_start_addr == FES_MID_BASE && erase_last_addr == FES_MID_LAST)
    else $error("mid block range wrong");
  prot_erase_a: assert property (program_erase_protect |=> !erase_valid)
    else $error("erase offered while protected");
  win_off_a: assert property (win_off_rd |=> bus_rdata == 8'h00)
    else $error("closed window answered");
  redir_addr_a: assert property (ram_redirect |-> $past(bus_req.rd) &&
    ram_redirect_addr == {FES_RAM_OVL_BASE[23:12], $past(bus_req.addr[11:0])})
    else $error("redirect address wrong");
endmodule

// *** fes_cpu.sv ***
// cpu model issuing single register and flash accesses
`timescale 1ns/100ps
module fes_cpu
  import fes_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // bus towards the block
  output fes_pkg::fes_bus_req_s bus_req,
  input wire logic [7:0] bus_rdata
);
  initial bus_req = '0;
  // runs in user mode only; an idle cycle separates accesses
  task automatic acc(input logic w, input logic [23:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    bus_req <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk_sys);
    bus_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    @(negedge clk_sys);
    q = bus_rdata;
  endtask
endmodule

// *** tb_flash_erase_select_ram_overlay.sv ***
// bench: register walk of erase select, overlay and error status
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected %0t: got %h want %h", $time, a, e); end end
module tb_flash_erase_select_ram_overlay;
  import fes_pkg::*;
  logic clk_sys = 0;
  logic reset_n = 0;
  logic software_write_enable = 0;
  logic flash_reg_window_enable = 0;
  logic prog_erase_fail = 0;
  fes_bus_req_s bus_req;
  logic [7:0] bus_rdata, q;
  logic bus_rvalid, erase_valid, flash_error_flag;
  logic program_erase_protect, ram_redirect;
  logic [11:0] erase_block_mask;
  logic [23:0] erase_start_addr, erase_last_addr, ram_redirect_addr, e;
  int n_fail = 0;
  int checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  fes_top u_dut (.*);
  fes_cpu u_cpu (.clk_sys(clk_sys), .bus_req(bus_req), .bus_rdata(bus_rdata));
  task automatic set(input logic s, input logic w, input logic f);
    @(posedge clk_sys);
    software_write_enable <= s;
    flash_reg_window_enable <= w;
    prog_erase_fail <= f;
  endtask
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    u_cpu.acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] x);
    u_cpu.acc(1'b0, a, 8'h00, q);
    `CHK({bus_rvalid, q}, {1'b1, x})
  endtask
  task automatic give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    set(0, 1, 0);
    rd(FES_ADDR_OVL, 8'h00);
    wr(FES_ADDR_SEL_LO, 8'h04);
    rd(FES_ADDR_SEL_LO, 8'h00);
    wr(FES_ADDR_SEL_HI, 8'h02);
    rd(FES_ADDR_SEL_HI, 8'h00);
    set(1, 1, 0);
    // low written before high so the move to bit 8 never holds two bits
    for (int i = 0; i < 12; i++) begin
      wr(FES_ADDR_SEL_LO, i < 8 ? 8'h01 << i : 8'h00);
      wr(FES_ADDR_SEL_HI, i < 8 ? 8'h00 : 8'h01 << (i - 8));
      rd(i < 8 ? FES_ADDR_SEL_LO : FES_ADDR_SEL_HI, 8'h01 << (i % 8));
      e = 24'(i < 8 ? i * 24'h1000 : i == 8 ? FES_MID_BASE : (i - 8) * FES_BIG_BLK);
      `CHK({erase_valid, erase_block_mask, erase_start_addr}, {1'b1, 12'h001 << i, e})
      `CHK(erase_last_addr, e + (i < 8 ? 24'hfff : i == 8 ? 24'h7fff : 24'hffff))
    end
    wr(FES_ADDR_SEL_LO, 8'h01);
    rd(FES_ADDR_SEL_HI, 8'h00);
    rd(FES_ADDR_SEL_LO, 8'h00);
    wr(FES_ADDR_SEL_LO, 8'h02);
    set(1, 0, 0);
    rd(FES_ADDR_SEL_LO, 8'h00);
    wr(FES_ADDR_SEL_LO, 8'h10);
    set(1, 1, 0);
    rd(FES_ADDR_SEL_LO, 8'h02);
    set(0, 1, 0);
    rd(FES_ADDR_SEL_LO, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(FES_ADDR_OVL, {5'h01, k[2:0]});
      rd(FES_ADDR_STATUS, 8'h00);
      u_cpu.acc(1'b0, {9'h000, k[2:0], 12'h010}, 8'h00, q);
      `CHK({ram_redirect, ram_redirect_addr, program_erase_protect}, {1'b1, FES_RAM_OVL_BASE + 24'h10, 1'b1})
      u_cpu.acc(1'b0, {9'h000, ~k[2], k[1:0], 12'h010}, 8'h00, q);
      `CHK(ram_redirect, 1'b0)
      rd(FES_ADDR_OVL, {5'h01, k[2:0]});
    end
    // overlay still on: a selected block must not be offered for erase
    set(1, 1, 0);
    wr(FES_ADDR_SEL_LO, 8'h01);
    rd(FES_ADDR_SEL_LO, 8'h01);
    `CHK({erase_valid, erase_block_mask}, {1'b0, 12'h001})
    wr(FES_ADDR_OVL, 8'h02);
    u_cpu.acc(1'b0, 24'h002000, 8'h00, q);
    `CHK({ram_redirect, program_erase_protect, erase_valid}, 3'b001)
    rd(FES_ADDR_STATUS, 8'h00);
    set(0, 1, 1);
    set(0, 1, 0);
    wr(FES_ADDR_STATUS, 8'h00);
    rd(FES_ADDR_STATUS, 8'h80);
    `CHK({flash_error_flag, program_erase_protect}, 2'b11)
    // only a reset clears the sticky error flag
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(FES_ADDR_STATUS, 8'h00);
    `CHK({flash_error_flag, program_erase_protect}, 2'b00)
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    give_verdict();
  end
endmodule
bind fes_top fes_sva u_sva (.*);
